/* File: design/occr_consts.svh */
`ifndef OCCR_CONSTS_SVH
`define OCCR_CONSTS_SVH

// Register addresses: set/clear pairs, then plain read/write registers
`define OCCR_MISC_SET_ADDR      8'h18
`define OCCR_MISC_CLR_ADDR      8'h19
`define OCCR_AUDIO_SET_ADDR     8'h1A
`define OCCR_AUDIO_CLR_ADDR     8'h1B
`define OCCR_TX_HIGH_ADDR       8'h1C
`define OCCR_TX_LOW_ADDR        8'h1D
`define OCCR_RX_RECOVERY_ADDR   8'h1E
`define OCCR_IRQ_DELAY_ADDR     8'h1F

// Misc control fields
`define OCCR_MISC_BYPASS_DIS_BIT 0
`define OCCR_MISC_SRP_START_BIT  1
`define OCCR_MISC_DP_WEAK_BIT    2
`define OCCR_MISC_ID_PU_OFF_BIT  3
`define OCCR_MISC_LOW_VSEL_BIT   4
`define OCCR_MISC_IMPL_MASK      8'h1F
`define OCCR_MISC_RESET          8'h10

// Accessory audio control fields
`define OCCR_AUDIO_TX_EN_BIT     0
`define OCCR_AUDIO_RX_EN_BIT     1
`define OCCR_AUDIO_LBIAS_BIT     2
`define OCCR_AUDIO_RBIAS_BIT     3
`define OCCR_AUDIO_LSW_BIT       4
`define OCCR_AUDIO_RSW_BIT       5
`define OCCR_AUDIO_IMPL_MASK     8'h3F
`define OCCR_AUDIO_RESET         8'h00

// Timing register reset values
`define OCCR_TX_HIGH_RESET       8'h15
`define OCCR_TX_LOW_RESET        8'h2A
`define OCCR_RX_RECOVERY_RESET   8'h64
`define OCCR_IRQ_DELAY_RESET     8'hC8

// Time base
`define OCCR_CLK_PERIOD_NS       20
`define OCCR_TICK_NS             250000
`define OCCR_TICK_CYCLES         (`OCCR_TICK_NS / `OCCR_CLK_PERIOD_NS)

// Session-request phase lengths in microseconds, converted to 0.25 ms ticks
`define OCCR_TICK_US             250
`define OCCR_SRP_DP_US           7500
`define OCCR_SRP_CHRG_US         32000
`define OCCR_SRP_DISCH_US        13000
`define OCCR_SRP_DP_TICKS        (`OCCR_SRP_DP_US / `OCCR_TICK_US)
`define OCCR_SRP_CHRG_TICKS      (`OCCR_SRP_CHRG_US / `OCCR_TICK_US)
`define OCCR_SRP_DISCH_TICKS     (`OCCR_SRP_DISCH_US / `OCCR_TICK_US)

`endif

/* File: design/occr_pkg.sv */
package occr_pkg;

	// Session-request sequencer states
	typedef enum logic [1:0] {
		OCCR_SRP_IDLE  = 2'b00,
		OCCR_SRP_DP    = 2'b01,
		OCCR_SRP_CHRG  = 2'b10,
		OCCR_SRP_DISCH = 2'b11
	} occr_srp_state_t;

	// Transmit pulse generator states
	typedef enum logic [1:0] {
		OCCR_TX_IDLE = 2'b00,
		OCCR_TX_HIGH = 2'b01,
		OCCR_TX_LOW  = 2'b10
	} occr_tx_state_t;

	// One register access from the serial front end
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} occr_reg_req_t;

	// Analog switch and resistor controls
	typedef struct packed {
		logic regulator_low_voltage_select;
		logic regulator_bypass_on;
		logic id_pullup_on;
		logic dplus_weak_pullup_on;
		logic dplus_pullup_srp;
		logic vbus_charge_resistor;
		logic vbus_discharge_resistor;
		logic right_mic_switch_on;
		logic left_speaker_switch_on;
		logic right_line_bias_on;
		logic left_line_bias_on;
	} occr_analog_ctl_t;

endpackage : occr_pkg

/* File: design/occr_ctrl.sv */
// Function
// - Low-voltage select only acts with UART pass-through; 0 gives 3.3 V, 1 gives 2.8 V.
// - Low-voltage select plus UART pass-through forces the bypass switch off.
// - Misc bit 3: zero keeps ID pull-up on, one turns it off.
// - Misc bit 2 connects the weak D+ pull-up while set.
// - Session request: D+ pull-up 7.5 ms, charge 32 ms, discharge 13 ms, in order.
// - Session-request start clears itself when done; writing zero does nothing.
// - Bypass-disable zero: bypass on below 3.6 V supply; one: bypass off.
// - Audio bit 5 closes right/mic switch, bit 4 left switch; bits 7:6 reserved.
// - Audio bit 3 biases right line, bit 2 biases left line.
// - Audio bit 1 enables pulse receive, bit 0 pulse transmit; all reset zero.
// - Transmit high pulse lasts programmed clock count; resets to 15h.
// - Transmit low pulse lasts programmed clock count; resets to 2Ah.
// - Receive recovery time is value times 0.25 ms, reset 64h, only with receive on.
// - Interrupt detection time is value times 0.25 ms, reset C8h.
// - Delay zero: flag follows pin low; else flag after pin low programmed time.
`timescale 1ns/1ps
`include "occr_consts.svh"

module occr_ctrl
	import occr_pkg::*;
#(
	parameter int TICK_CYCLES = `OCCR_TICK_CYCLES
) (
	input  wire logic             mclk_in,
	input  wire logic             rst_in,
	input  wire occr_reg_req_t    reg_req_in,
	output logic [7:0]            reg_rdata_out,
	input  wire logic             uart_pass_en_in,
	input  wire logic             vcc_below_3v6_in,
	input  wire logic             accessory_irq_pin_low_in,
	input  wire logic             tx_pulse_req_in,
	input  wire logic             rx_edge_in,
	output occr_analog_ctl_t      analog_ctl_out,
	output logic                  srp_busy_out,
	output logic                  dm_tx_active_out,
	output logic                  dm_tx_level_out,
	output logic                  rx_recovery_busy_out,
	output logic                  accessory_irq_flag_out
);

	// Refuse a prescaler length that the 16-bit divider cannot count
	if (TICK_CYCLES < 2 || TICK_CYCLES > 65536) begin : g_tick_check
		$error("TICK_CYCLES out of range");
	end

	localparam int NCH = 3;  // Timer channels: 0 session request, 1 receive, 2 interrupt

	// Registers
	logic [7:0]      misc_ff;
	logic [7:0]      audio_ff;
	logic [7:0]      tx_high_ff;
	logic [7:0]      tx_low_ff;
	logic [7:0]      rx_recovery_ff;
	logic [7:0]      irq_delay_ff;
	logic [1:0]      vcc_sync_ff;
	logic [1:0]      irq_sync_ff;
	occr_srp_state_t srp_state_ff;
	occr_srp_state_t nxt_srp_state;
	logic [7:0]      srp_ticks_ff;
	occr_tx_state_t  tx_state_ff;
	logic [7:0]      tx_cnt_ff;
	logic            tx_level_ff;
	logic            rx_busy_ff;
	logic [7:0]      rx_ticks_ff;
	logic [7:0]      irq_ticks_ff;
	logic            irq_flag_ff;
	logic [NCH-1:0]  tick;
	logic [NCH-1:0]  tick_restart;

	// Address decode
	wire wr_misc_set  = reg_req_in.wr && reg_req_in.addr == `OCCR_MISC_SET_ADDR;
	wire wr_misc_clr  = reg_req_in.wr && reg_req_in.addr == `OCCR_MISC_CLR_ADDR;
	wire wr_audio_set = reg_req_in.wr && reg_req_in.addr == `OCCR_AUDIO_SET_ADDR;
	wire wr_audio_clr = reg_req_in.wr && reg_req_in.addr == `OCCR_AUDIO_CLR_ADDR;
	wire wr_tx_high   = reg_req_in.wr && reg_req_in.addr == `OCCR_TX_HIGH_ADDR;
	wire wr_tx_low    = reg_req_in.wr && reg_req_in.addr == `OCCR_TX_LOW_ADDR;
	wire wr_rx_rec    = reg_req_in.wr && reg_req_in.addr == `OCCR_RX_RECOVERY_ADDR;
	wire wr_irq_dly   = reg_req_in.wr && reg_req_in.addr == `OCCR_IRQ_DELAY_ADDR;

	// Synchronised pin levels
	wire vcc_low  = vcc_sync_ff[1];
	wire irq_low  = irq_sync_ff[1];

	// Field views
	wire low_vsel   = misc_ff[`OCCR_MISC_LOW_VSEL_BIT];
	wire bypass_dis = misc_ff[`OCCR_MISC_BYPASS_DIS_BIT];
	wire tx_en      = audio_ff[`OCCR_AUDIO_TX_EN_BIT];
	wire rx_en      = audio_ff[`OCCR_AUDIO_RX_EN_BIT];

	// Session request: start on a one written at the set address, done at end of discharge
	wire srp_start = wr_misc_set && reg_req_in.wdata[`OCCR_MISC_SRP_START_BIT];
	wire srp_abort = wr_misc_clr && reg_req_in.wdata[`OCCR_MISC_SRP_START_BIT];
	wire srp_done  = srp_state_ff == OCCR_SRP_DISCH && tick[0] &&
		srp_ticks_ff == 8'(`OCCR_SRP_DISCH_TICKS - 1);

	// Set/clear update; a sequencer restart in the completion cycle keeps the bit set
	wire [7:0] misc_wset = wr_misc_set ? reg_req_in.wdata : 8'h00;
	wire [7:0] misc_wclr = wr_misc_clr ? reg_req_in.wdata : 8'h00;
	wire [7:0] misc_auto = srp_done ? (8'h01 << `OCCR_MISC_SRP_START_BIT) : 8'h00;
	wire [7:0] nxt_misc  = ((misc_ff & ~misc_wclr & ~misc_auto) | misc_wset)
		& `OCCR_MISC_IMPL_MASK;
	wire [7:0] audio_wset = wr_audio_set ? reg_req_in.wdata : 8'h00;
	wire [7:0] audio_wclr = wr_audio_clr ? reg_req_in.wdata : 8'h00;
	wire [7:0] nxt_audio  = ((audio_ff & ~audio_wclr) | audio_wset)
		& `OCCR_AUDIO_IMPL_MASK;

	// Read mux; both addresses of a pair return the current value, unmapped reads zero
	assign reg_rdata_out =
		(reg_req_in.addr == `OCCR_MISC_SET_ADDR  ||
		 reg_req_in.addr == `OCCR_MISC_CLR_ADDR)   ? misc_ff :
		(reg_req_in.addr == `OCCR_AUDIO_SET_ADDR ||
		 reg_req_in.addr == `OCCR_AUDIO_CLR_ADDR)  ? audio_ff :
		(reg_req_in.addr == `OCCR_TX_HIGH_ADDR)     ? tx_high_ff :
		(reg_req_in.addr == `OCCR_TX_LOW_ADDR)      ? tx_low_ff :
		(reg_req_in.addr == `OCCR_RX_RECOVERY_ADDR) ? rx_recovery_ff :
		(reg_req_in.addr == `OCCR_IRQ_DELAY_ADDR)   ? irq_delay_ff : 8'h00;

	// Register storage
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			misc_ff        <= `OCCR_MISC_RESET;
			audio_ff       <= `OCCR_AUDIO_RESET;
			tx_high_ff     <= `OCCR_TX_HIGH_RESET;
			tx_low_ff      <= `OCCR_TX_LOW_RESET;
			rx_recovery_ff <= `OCCR_RX_RECOVERY_RESET;
			irq_delay_ff   <= `OCCR_IRQ_DELAY_RESET;
		end else begin
			misc_ff        <= nxt_misc;
			audio_ff       <= nxt_audio;
			tx_high_ff     <= wr_tx_high ? reg_req_in.wdata : tx_high_ff;
			tx_low_ff      <= wr_tx_low  ? reg_req_in.wdata : tx_low_ff;
			rx_recovery_ff <= wr_rx_rec  ? reg_req_in.wdata : rx_recovery_ff;
			irq_delay_ff   <= wr_irq_dly ? reg_req_in.wdata : irq_delay_ff;
		end
	end

	// Two-flop synchronisers for the analog comparator levels
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			vcc_sync_ff <= 2'b00;
			irq_sync_ff <= 2'b00;
		end else begin
			vcc_sync_ff <= {vcc_sync_ff[0], vcc_below_3v6_in};
			irq_sync_ff <= {irq_sync_ff[0], accessory_irq_pin_low_in};
		end
	end

	// Restartable 0.25 ms prescalers, one per timer so every interval starts on a full tick
	assign tick_restart[0] = srp_start;
	assign tick_restart[1] = rx_en && rx_edge_in;
	assign tick_restart[2] = !irq_low;
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_tick
			logic [15:0] div_ff;
			assign tick[g] = div_ff == 16'(TICK_CYCLES - 1);
			always_ff @(posedge mclk_in) begin
				if (rst_in || tick_restart[g] || tick[g]) begin
					div_ff <= 16'h0000;
				end else begin
					div_ff <= div_ff + 16'h0001;
				end
			end
		end
	endgenerate

	// Session-request sequencer, phases counted in ticks
	always_comb begin
		nxt_srp_state = srp_state_ff;
		case (srp_state_ff)
			OCCR_SRP_IDLE: begin
				nxt_srp_state = OCCR_SRP_IDLE;
			end
			OCCR_SRP_DP: begin
				if (tick[0] && srp_ticks_ff == 8'(`OCCR_SRP_DP_TICKS - 1)) begin
					nxt_srp_state = OCCR_SRP_CHRG;
				end
			end
			OCCR_SRP_CHRG: begin
				if (tick[0] && srp_ticks_ff == 8'(`OCCR_SRP_CHRG_TICKS - 1)) begin
					nxt_srp_state = OCCR_SRP_DISCH;
				end
			end
			OCCR_SRP_DISCH: begin
				if (srp_done) begin
					nxt_srp_state = OCCR_SRP_IDLE;
				end
			end
			default: begin
				nxt_srp_state = OCCR_SRP_IDLE;
			end
		endcase
		if (srp_abort) begin
			nxt_srp_state = OCCR_SRP_IDLE;
		end
		if (srp_start) begin
			nxt_srp_state = OCCR_SRP_DP;
		end
	end

	// Sequencer state and phase tick count
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			srp_state_ff <= OCCR_SRP_IDLE;
			srp_ticks_ff <= 8'h00;
		end else begin
			srp_state_ff <= nxt_srp_state;
			if (srp_start || nxt_srp_state != srp_state_ff) begin
				srp_ticks_ff <= 8'h00;
			end else if (tick[0]) begin
				srp_ticks_ff <= srp_ticks_ff + 8'h01;
			end
		end
	end

	// Transmit pulse: high for the high count, then low for the low count
	always_ff @(posedge mclk_in) begin
		if (rst_in || !tx_en) begin
			tx_state_ff <= OCCR_TX_IDLE;
			tx_cnt_ff   <= 8'h00;
			tx_level_ff <= 1'b0;
		end else begin
			case (tx_state_ff)
				OCCR_TX_IDLE: begin
					if (tx_pulse_req_in) begin
						tx_state_ff <= OCCR_TX_HIGH;
						tx_cnt_ff   <= 8'h01;
						tx_level_ff <= 1'b1;
					end
				end
				OCCR_TX_HIGH: begin
					if (tx_cnt_ff >= tx_high_ff) begin
						tx_state_ff <= OCCR_TX_LOW;
						tx_cnt_ff   <= 8'h01;
						tx_level_ff <= 1'b0;
					end else begin
						tx_cnt_ff <= tx_cnt_ff + 8'h01;
					end
				end
				OCCR_TX_LOW: begin
					if (tx_cnt_ff >= tx_low_ff) begin
						tx_state_ff <= OCCR_TX_IDLE;
						tx_cnt_ff   <= 8'h00;
					end else begin
						tx_cnt_ff <= tx_cnt_ff + 8'h01;
					end
				end
				default: begin
					tx_state_ff <= OCCR_TX_IDLE;
					tx_cnt_ff   <= 8'h00;
					tx_level_ff <= 1'b0;
				end
			endcase
		end
	end

	// Receive polarity recovery: a new edge restarts the window
	always_ff @(posedge mclk_in) begin
		if (rst_in || !rx_en) begin
			rx_busy_ff  <= 1'b0;
			rx_ticks_ff <= 8'h00;
		end else if (rx_edge_in) begin
			rx_busy_ff  <= rx_recovery_ff != 8'h00;
			rx_ticks_ff <= 8'h00;
		end else if (rx_busy_ff && tick[1]) begin
			rx_ticks_ff <= rx_ticks_ff + 8'h01;
			if (rx_ticks_ff + 8'h01 >= rx_recovery_ff) begin
				rx_busy_ff <= 1'b0;
			end
		end
	end

	// Interrupt debounce; the count saturates so a long low never wraps
	always_ff @(posedge mclk_in) begin
		if (rst_in || !irq_low) begin
			irq_ticks_ff <= 8'h00;
			irq_flag_ff  <= 1'b0;
		end else if (irq_delay_ff == 8'h00) begin
			irq_flag_ff <= 1'b1;
		end else if (tick[2] && !irq_flag_ff) begin
			irq_ticks_ff <= irq_ticks_ff + 8'h01;
			if (irq_ticks_ff + 8'h01 >= irq_delay_ff) begin
				irq_flag_ff <= 1'b1;
			end
		end
	end

	// Analog controls; bypass follows the synchronised supply level and is forced off by low-voltage select with UART pass-through
	assign analog_ctl_out.regulator_low_voltage_select = low_vsel && uart_pass_en_in;
	assign analog_ctl_out.regulator_bypass_on = vcc_low && !bypass_dis &&
		!(low_vsel && uart_pass_en_in);
	assign analog_ctl_out.id_pullup_on = !misc_ff[`OCCR_MISC_ID_PU_OFF_BIT];
	assign analog_ctl_out.dplus_weak_pullup_on = misc_ff[`OCCR_MISC_DP_WEAK_BIT];
	assign analog_ctl_out.dplus_pullup_srp = srp_state_ff == OCCR_SRP_DP;
	assign analog_ctl_out.vbus_charge_resistor = srp_state_ff == OCCR_SRP_CHRG;
	assign analog_ctl_out.vbus_discharge_resistor = srp_state_ff == OCCR_SRP_DISCH;
	assign analog_ctl_out.right_mic_switch_on = audio_ff[`OCCR_AUDIO_RSW_BIT];
	assign analog_ctl_out.left_speaker_switch_on = audio_ff[`OCCR_AUDIO_LSW_BIT];
	assign analog_ctl_out.right_line_bias_on = audio_ff[`OCCR_AUDIO_RBIAS_BIT];
	assign analog_ctl_out.left_line_bias_on = audio_ff[`OCCR_AUDIO_LBIAS_BIT];

	// Status outputs
	assign srp_busy_out           = srp_state_ff != OCCR_SRP_IDLE;
	assign dm_tx_active_out       = tx_state_ff != OCCR_TX_IDLE;
	assign dm_tx_level_out        = tx_level_ff;
	assign rx_recovery_busy_out   = rx_busy_ff;
	assign accessory_irq_flag_out = irq_flag_ff;

endmodule : occr_ctrl

/* File: bench/occr_ctrl_asserts.sv */
`timescale 1ns/1ps
module occr_ctrl_asserts
	import occr_pkg::*;
#(
	parameter int TICK_CYCLES = 4
) (
	input  wire logic          mclk_in,
	input  wire logic          rst_in,
	input  wire occr_reg_req_t reg_req_in,
	input  wire logic [7:0]    reg_rdata_out,
	input  wire logic          uart_pass_en_in,
	input  wire logic          accessory_irq_pin_low_in,
	input  wire occr_analog_ctl_t analog_ctl_out,
	input  wire logic          srp_busy_out,
	input  wire logic          dm_tx_active_out,
	input  wire logic          dm_tx_level_out,
	input  wire logic          rx_recovery_busy_out,
	input  wire logic          accessory_irq_flag_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	// Read data is combinational, so an address parked on a register exposes it
	wire       misc_rd = reg_req_in.addr == 8'h18;
	wire       aud_rd  = reg_req_in.addr == 8'h1A || reg_req_in.addr == 8'h1B;
	wire       srp_go  = reg_req_in.wr && misc_rd && reg_req_in.wdata[1];
	wire [2:0] srp_res = {analog_ctl_out.dplus_pullup_srp, analog_ctl_out.vbus_charge_resistor,
		analog_ctl_out.vbus_discharge_resistor};
	sequence srp_req; srp_go; endsequence
	sequence dp_phase; srp_busy_out && srp_res == 3'b100; endsequence
	AST_LOW_VSEL: assert property (
		misc_rd |-> analog_ctl_out.regulator_low_voltage_select == (reg_rdata_out[4] && uart_pass_en_in)
	) else $error("low voltage select wrong");
	AST_BYPASS_FORCED: assert property (
		(misc_rd && reg_rdata_out[4] && uart_pass_en_in) |-> !analog_ctl_out.regulator_bypass_on
	) else $error("bypass not forced off");
	AST_ID_PULLUP: assert property (
		misc_rd |-> analog_ctl_out.id_pullup_on == !reg_rdata_out[3]) else $error("id pullup wrong");
	AST_WEAK_PULLUP: assert property (
		misc_rd |-> analog_ctl_out.dplus_weak_pullup_on == reg_rdata_out[2]) else $error("weak pullup");
	AST_SRP_LAUNCH: assert property (
		srp_req |=> dp_phase [*2]) else $error("session request did not start");
	AST_SRP_ORDER: assert property (
		($rose(srp_res[1]) |-> $past(srp_res) == 3'b100) and ($rose(srp_res[0]) |-> $past(srp_res) == 3'b010)
	) else $error("session request phase order");
	AST_SRP_ONEHOT: assert property (
		srp_busy_out |-> $onehot(srp_res)) else $error("session request outputs overlap");
	AST_SRP_SELF_CLEAR: assert property (
		misc_rd |-> reg_rdata_out[1] == srp_busy_out) else $error("start bit disagrees with busy");
	AST_BYPASS_DIS: assert property (
		(misc_rd && reg_rdata_out[0]) |-> !analog_ctl_out.regulator_bypass_on) else $error("bypass on");
	AST_AUDIO_SW: assert property (
		aud_rd |-> {analog_ctl_out.right_mic_switch_on, analog_ctl_out.left_speaker_switch_on,
		analog_ctl_out.right_line_bias_on, analog_ctl_out.left_line_bias_on,
		reg_rdata_out[7:6]} == {reg_rdata_out[5:2], 2'b00}) else $error("audio switches wrong");
	AST_TX_SHAPE: assert property (
		($rose(dm_tx_active_out) |-> dm_tx_level_out) and ($fell(dm_tx_level_out) |-> dm_tx_active_out)
	) else $error("pulse shape wrong");
	AST_RX_OFF: assert property (
		(aud_rd && !reg_rdata_out[1]) [*3] |-> !rx_recovery_busy_out) else $error("recovery while off");
	AST_IRQ_RELEASE: assert property (
		(!accessory_irq_pin_low_in) [*5] |-> !accessory_irq_flag_out) else $error("flag stuck");
endmodule : occr_ctrl_asserts

bind occr_ctrl occr_ctrl_asserts #(.TICK_CYCLES(TICK_CYCLES)) occr_ctrl_asserts_inst (.mclk_in,
	.rst_in, .reg_req_in, .reg_rdata_out, .uart_pass_en_in, .accessory_irq_pin_low_in,
	.analog_ctl_out, .srp_busy_out, .dm_tx_active_out, .dm_tx_level_out, .rx_recovery_busy_out,
	.accessory_irq_flag_out);

/* File: bench/occr_host_model.sv */
`timescale 1ns/1ps
module occr_host_model
	import occr_pkg::*;
(
	input  wire logic       mclk_in,
	input  wire logic [7:0] rdata_in,
	output occr_reg_req_t   req_out
);
	// Parked on an unmapped address so nothing is selected at start
	initial req_out = '{wr: 1'b0, addr: 8'hFF, wdata: 8'h00};
	// One-cycle strobe; data is scrambled after release so stale bytes never look valid
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		req_out <= '{wr: 1'b1, addr: a, wdata: d};
		@(posedge mclk_in);
		req_out <= '{wr: 1'b0, addr: a, wdata: ~d};
	endtask : wr_reg
	// Read has no strobe, so the address is held a full cycle before sampling
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_in);
		req_out.addr <= a;
		@(posedge mclk_in);
		#1 d = rdata_in;
	endtask : rd_reg
endmodule : occr_host_model

/* File: bench/occr_ctrl_tb.sv */
`timescale 1ns/1ps
module occr_ctrl_tb;
	import occr_pkg::*;
	localparam int TICK = 4;
	logic             mclk_in, rst_in, uart, vcc_low, pin_low, tx_req, rx_edge;
	logic [7:0]       rdata;
	logic [7:0]       ra [9] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20};
	logic [7:0]       rv [9] = '{8'h10, 8'h10, 8'h00, 8'h00, 8'h15, 8'h2A, 8'h64, 8'hC8, 8'h00};
	occr_reg_req_t    req;
	occr_analog_ctl_t ana;
	logic             srp_busy, tx_act, tx_lvl, rx_busy, irq_flag;
	int               errors, comparisons, t, n;
	// Monitored levels: 6 D+ srp, 5 charge, 4 discharge, 3 high, 2 low, 1 rx, 0 flag
	wire [6:0] mon = {ana.dplus_pullup_srp, ana.vbus_charge_resistor, ana.vbus_discharge_resistor,
		tx_lvl, tx_act & ~tx_lvl, rx_busy, irq_flag};

	occr_ctrl #(.TICK_CYCLES(TICK)) occr_ctrl_inst (.mclk_in(mclk_in), .rst_in(rst_in),
		.reg_req_in(req), .reg_rdata_out(rdata), .uart_pass_en_in(uart),
		.vcc_below_3v6_in(vcc_low), .accessory_irq_pin_low_in(pin_low), .tx_pulse_req_in(tx_req),
		.rx_edge_in(rx_edge), .analog_ctl_out(ana), .srp_busy_out(srp_busy),
		.dm_tx_active_out(tx_act), .dm_tx_level_out(tx_lvl), .rx_recovery_busy_out(rx_busy),
		.accessory_irq_flag_out(irq_flag));
	occr_host_model occr_host_model_inst (.mclk_in(mclk_in), .rdata_in(rdata), .req_out(req));

	initial begin
		mclk_in = 1'b0;
		forever #10 mclk_in = ~mclk_in;
	end

	task automatic summarize();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize

	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk

	task automatic rd_chk(logic [7:0] a, logic [7:0] e);
		logic [7:0] v;
		occr_host_model_inst.rd_reg(a, v);
		chk($sformatf("reg %0h", a), {8'h00, e}, {8'h00, v});
	endtask : rd_chk

	// Time until a level rises, then how long it stays; a bound guards each wait
	task automatic span(int idx, int lim, bit hold, output int tw, output int nh);
		#1;
		tw = 0;
		nh = 0;
		while (!mon[idx] && tw < lim) begin @(posedge mclk_in); #1; tw++; end
		while (hold && mon[idx] && nh < lim) begin @(posedge mclk_in); #1; nh++; end
		if (tw >= lim || nh >= lim) begin
			errors++;
			$display("[FAIL] monitor bit %0d expected change within %0d seen none", idx, lim);
			summarize();
		end
	endtask : span

	task automatic pulse_in(bit rx);
		@(posedge mclk_in);
		if (rx) rx_edge <= 1'b1; else tx_req <= 1'b1;
		@(posedge mclk_in);
		rx_edge <= 1'b0;
		tx_req <= 1'b0;
	endtask : pulse_in

	// Analog outputs are checked as a whole vector, MSB = low voltage select
	initial begin
		errors = 0;
		comparisons = 0;
		{rst_in, uart, vcc_low, pin_low, tx_req, rx_edge} = 6'b111000;
		repeat (3) @(posedge mclk_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 9; i++) rd_chk(ra[i], rv[i]);
		$display("test reset values done");
		occr_host_model_inst.wr_reg(8'h18, 8'h0C);
		#1 chk("analog", 16'h0480, {5'h00, ana});
		occr_host_model_inst.wr_reg(8'h19, 8'h04);
		rd_chk(8'h19, 8'h18);
		occr_host_model_inst.wr_reg(8'h19, 8'h08);
		#1 chk("analog", 16'h0500, {5'h00, ana});
		occr_host_model_inst.wr_reg(8'h1A, 8'hFF);
		rd_chk(8'h1A, 8'h3F);
		chk("analog", 16'h050F, {5'h00, ana});
		occr_host_model_inst.wr_reg(8'h1B, 8'h33);
		rd_chk(8'h1B, 8'h0C);
		chk("analog", 16'h0503, {5'h00, ana});
		occr_host_model_inst.wr_reg(8'h1B, 8'h0C);
		$display("test set clear done");
		uart <= 1'b0;
		rd_chk(8'h18, 8'h10);
		chk("analog", 16'h0300, {5'h00, ana});
		occr_host_model_inst.wr_reg(8'h18, 8'h01);
		#1 chk("analog", 16'h0100, {5'h00, ana});
		@(posedge mclk_in) uart <= 1'b1;
		rd_chk(8'h18, 8'h11);
		chk("analog", 16'h0500, {5'h00, ana});
		occr_host_model_inst.wr_reg(8'h19, 8'h11);
		#1 chk("analog", 16'h0300, {5'h00, ana});
		// Supply above the bypass threshold: switch must open after the synchroniser
		@(posedge mclk_in) vcc_low <= 1'b0;
		repeat (3) @(posedge mclk_in);
		#1 chk("bypass high vcc", 16'h0100, {5'h00, ana});
		@(posedge mclk_in) vcc_low <= 1'b1;
		$display("test regulator done");
		occr_host_model_inst.wr_reg(8'h18, 8'h00);
		#1 chk("srp idle", 16'h0000, {15'h0000, srp_busy});
		occr_host_model_inst.wr_reg(8'h18, 8'h02);
		span(6, 2000, 1'b1, t, n);
		chk("dp phase", 16'(30 * TICK), 16'(n));
		span(5, 2000, 1'b1, t, n);
		chk("charge phase", 16'(128 * TICK), 16'(n));
		span(4, 2000, 1'b1, t, n);
		chk("discharge phase", 16'(52 * TICK), 16'(n));
		rd_chk(8'h18, 8'h00);
		// Start then abort through the clear address
		occr_host_model_inst.wr_reg(8'h18, 8'h02);
		repeat (5) @(posedge mclk_in);
		occr_host_model_inst.wr_reg(8'h19, 8'h02);
		#1 chk("srp abort", 16'h0000, {15'h0000, srp_busy});
		rd_chk(8'h18, 8'h00);
		$display("test session request done");
		occr_host_model_inst.wr_reg(8'h1C, 8'h03);
		occr_host_model_inst.wr_reg(8'h1D, 8'h05);
		occr_host_model_inst.wr_reg(8'h1A, 8'h01);
		pulse_in(1'b0);
		span(3, 600, 1'b1, t, n);
		chk("high width", 16'h0003, 16'(n));
		span(2, 600, 1'b1, t, n);
		chk("low width", 16'h0005, 16'(n));
		occr_host_model_inst.wr_reg(8'h1B, 8'h01);
		pulse_in(1'b0);
		repeat (3) @(posedge mclk_in);
		#1 chk("tx off", 16'h0000, {15'h0000, tx_act});
		$display("test pulse transmit done");
		occr_host_model_inst.wr_reg(8'h1E, 8'h02);
		occr_host_model_inst.wr_reg(8'h1A, 8'h02);
		pulse_in(1'b1);
		span(1, 600, 1'b1, t, n);
		chk("recovery", 16'(2 * TICK), 16'(n));
		// Disabling receive in mid-window must end the window at once
		pulse_in(1'b1);
		occr_host_model_inst.wr_reg(8'h1B, 8'h02);
		@(posedge mclk_in);
		#1 chk("recovery off", 16'h0000, {15'h0000, rx_busy});
		$display("test recovery done");
		occr_host_model_inst.wr_reg(8'h1F, 8'h00);
		pin_low <= 1'b1;
		span(0, 600, 1'b0, t, n);
		chk("direct flag", 16'h0001, 16'(t >= 2 && t <= 4));
		@(posedge mclk_in) pin_low <= 1'b0;
		repeat (6) @(posedge mclk_in);
		#1 chk("flag release", 16'h0000, {15'h0000, irq_flag});
		occr_host_model_inst.wr_reg(8'h1F, 8'h03);
		pin_low <= 1'b1;
		span(0, 600, 1'b0, t, n);
		chk("delayed flag", 16'h0001, 16'(t >= 3 * TICK && t <= 3 * TICK + 4));
		@(posedge mclk_in) pin_low <= 1'b0;
		$display("test interrupt delay done");
		summarize();
	end
endmodule : occr_ctrl_tb
